// *** aus_pkg.sv ***
// Purpose: Shared constants and carriers for the uncorrectable error status bank
// Assumes: AXI4-Lite register access, 32-bit data, 12-bit byte address
// Notes:   Printed offsets are byte addresses
package aus_pkg;

    // ****************
    // Widths and register map
    // ****************
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam int          STRB_W       = 4;
    localparam int          PTR_W        = 12;
    localparam logic [11:0] OFS_HEADER   = 12'h100;
    localparam logic [11:0] OFS_STATUS   = 12'h104;

    // ****************
    // Capability header fields
    // ****************
    localparam logic [15:0] CAP_ID       = 16'h0001;
    localparam logic [3:0]  CAP_VER      = 4'h1;
    localparam logic [11:0] NEXT_PTR_RST = 12'h000;
    localparam int          PTR_LO_BIT   = 20;
    localparam int          PTR_LO_TOP   = 23;
    localparam int          PTR_HI_BIT   = 24;
    localparam int          PTR_HI_TOP   = 31;
    localparam int          PTR_LO_LANE  = 2;
    localparam int          PTR_HI_LANE  = 3;
    localparam int          PTR_SPLIT    = 4;

    // ****************
    // Status bit positions
    // ****************
    localparam int          BIT_UNUSED   = 0;
    localparam int          BIT_DLP      = 4;
    localparam int          BIT_SDN      = 5;
    localparam int          BIT_POIS     = 12;
    localparam int          BIT_FCP      = 13;
    localparam int          BIT_CTO      = 14;
    localparam int          BIT_CAB      = 15;
    localparam int          BIT_UCMP     = 16;
    localparam int          BIT_ROVR     = 17;
    localparam int          BIT_MALF     = 18;
    localparam int          BIT_ECRC     = 19;
    localparam int          BIT_UR       = 20;
    localparam int          BIT_ACV      = 21;
    localparam int          BIT_UIE      = 22;
    localparam int          BIT_MCB      = 23;
    // Bits that hold a sticky flag; all others read zero
    localparam logic [31:0] STICKY_MASK  = 32'h00ff3031;
    localparam logic [31:0] STATUS_RST   = 32'h00000000;

    // ****************
    // AXI responses
    // ****************
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Detection pulses from the link and transaction layers
    typedef struct packed {
        logic link_protocol_error;
        logic surprise_down;
        logic poisoned_tlp;
        logic flow_control_error;
        logic unexpected_completion;
        logic receiver_overflow;
        logic malformed_tlp;
        logic ecrc_error;
        logic unsupported_request;
        logic access_control_violation;
        logic internal_error;
        logic multicast_blocked;
    } aus_event_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0]        prot;
    } aus_addr_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } aus_wdata_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0]        resp;
    } aus_rdata_t;

    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESPOND = 1'b1
    } aus_wr_state_t;

    typedef enum logic [0:0] {
        RD_IDLE    = 1'b0,
        RD_RESPOND = 1'b1
    } aus_rd_state_t;

endpackage

// *** aus_sticky_flag.sv ***
// Purpose: One sticky write-one-to-clear status flag
// Assumes: Set and clear are single-cycle strobes on i_mclk
// Notes:   Only the power-on reset clears it
`timescale 1ns/1ps
module aus_sticky_flag (
    input  wire logic i_mclk,
    input  wire logic i_por_resetn,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);

    // ************************************************************
    // Flag storage
    // ************************************************************
    logic next_flag;

    // Set beats a clear in the same cycle, so no event is lost
    always_comb begin
        next_flag = i_set | (o_flag & ~i_clear);
    end

    // Survives every reset except power-on
    always_ff @(posedge i_mclk) begin
        if (!i_por_resetn) begin
            o_flag <= 1'b0;
        end else begin
            o_flag <= next_flag;
        end
    end

endmodule

// *** aer_uncorrectable_status.sv ***
// Purpose: Error reporting capability header and uncorrectable status bank
// Assumes: Event pulses come from logic on i_mclk; AXI4-Lite register access
// Notes:   Sticky flags and status output registers use i_por_resetn, all other state uses i_resetn
//
// Function
// - Capability identifier reads constant one
// - Capability version reads constant one
// - Next pointer writable only when unlocked
// - Link protocol error sets bit four
// - Surprise down sets bit five if capable
// - Poisoned packet sets bit twelve
// - Flow control violation sets bit thirteen
// - Completion timeout bit always zero
// - Completer abort never set; violation instead
// - Unexpected completion sets bit sixteen
// - Receive overflow sets bit seventeen
// - Malformed packet sets bit eighteen
// - ECRC failure sets bit nineteen
// - Unsupported request sets bit twenty
// - Access control violation sets bit twenty-one
// - Internal error sets bit twenty-two
// - Blocked multicast packet sets bit twenty-three
// - Bit zero sticky, clearable, never set
// - Masking never stops status bits setting
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module aer_uncorrectable_status #(
    parameter logic [11:0] P_NEXT_PTR_RESET = aus_pkg::NEXT_PTR_RST
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_por_resetn,
    input  aus_pkg::aus_event_t        i_event,
    input  wire logic                  i_surprise_down_report_capable,
    input  wire logic                  i_next_pointer_unlock,
    input  wire logic                  i_awvalid,
    input  aus_pkg::aus_addr_t         i_aw,
    output logic                       o_awready,
    input  wire logic                  i_wvalid,
    input  aus_pkg::aus_wdata_t        i_w,
    output logic                       o_wready,
    output logic                       o_bvalid,
    output logic [1:0]                 o_bresp,
    input  wire logic                  i_bready,
    input  wire logic                  i_arvalid,
    input  aus_pkg::aus_addr_t         i_ar,
    output logic                       o_arready,
    output logic                       o_rvalid,
    output aus_pkg::aus_rdata_t        o_r,
    input  wire logic                  i_rready,
    output logic [31:0]                o_uncorrectable_error_status,
    output logic                       o_uncorrectable_pending
);

    // ****************
    // Declarations
    // ****************
    aus_pkg::aus_wr_state_t            wr_state;
    aus_pkg::aus_rd_state_t            rd_state;
    logic                              aw_full;
    logic                              w_full;
    aus_pkg::aus_addr_t                aw_hold;
    aus_pkg::aus_wdata_t               w_hold;
    logic [11:0]                       next_capability_pointer;
    logic [31:0]                       status_flags;
    logic [31:0]                       set_vec;
    logic [31:0]                       clr_vec;
    logic [31:0]                       header_word;
    logic                              write_commit;
    logic                              wr_header;
    logic                              wr_status;
    logic                              wr_mapped;
    logic                              ar_take;
    logic                              rd_header;
    logic                              rd_status;
    aus_pkg::aus_rdata_t               next_r;

    // ****************
    // Capability header
    // ****************

    always_comb begin
        header_word = {next_capability_pointer, aus_pkg::CAP_VER, aus_pkg::CAP_ID};
    end

    // locked pointer write
    // Lock held by the port; a write while locked still completes OKAY
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            next_capability_pointer <= P_NEXT_PTR_RESET;
        end else if (write_commit && wr_header && i_next_pointer_unlock) begin
            if (w_hold.strb[aus_pkg::PTR_LO_LANE]) begin
                next_capability_pointer[aus_pkg::PTR_SPLIT-1:0] <=
                    w_hold.data[aus_pkg::PTR_LO_TOP:aus_pkg::PTR_LO_BIT];
            end
            if (w_hold.strb[aus_pkg::PTR_HI_LANE]) begin
                next_capability_pointer[aus_pkg::PTR_W-1:aus_pkg::PTR_SPLIT] <=
                    w_hold.data[aus_pkg::PTR_HI_TOP:aus_pkg::PTR_HI_BIT];
            end
        end
    end

    // ****************
    // Event to status bit mapping
    // ****************

    // Set vector built from detection pulses
    always_comb begin
        set_vec = '0;
        set_vec[aus_pkg::BIT_UNUSED] = 1'b0;
        set_vec[aus_pkg::BIT_DLP]    = i_event.link_protocol_error;
        set_vec[aus_pkg::BIT_SDN]    = i_event.surprise_down
                                     & i_surprise_down_report_capable;
        set_vec[aus_pkg::BIT_POIS]   = i_event.poisoned_tlp;
        set_vec[aus_pkg::BIT_FCP]    = i_event.flow_control_error;
        // no requests issued, bit never set
        set_vec[aus_pkg::BIT_CTO]    = 1'b0;
        set_vec[aus_pkg::BIT_CAB]    = 1'b0;
        set_vec[aus_pkg::BIT_UCMP]   = i_event.unexpected_completion;
        set_vec[aus_pkg::BIT_ROVR]   = i_event.receiver_overflow;
        set_vec[aus_pkg::BIT_MALF]   = i_event.malformed_tlp;
        set_vec[aus_pkg::BIT_ECRC]   = i_event.ecrc_error;
        set_vec[aus_pkg::BIT_UR]     = i_event.unsupported_request;
        // access control violation, also for abort cases
        set_vec[aus_pkg::BIT_ACV]    = i_event.access_control_violation;
        set_vec[aus_pkg::BIT_UIE]    = i_event.internal_error;
        set_vec[aus_pkg::BIT_MCB]    = i_event.multicast_blocked;
    end

    // ****************
    // Sticky status flags
    // ****************

    // One flag per implemented bit; the rest tie low
    // no mask term anywhere in the set path
    // reserved bits zero, sticky on power-on reset
    for (genvar gi = 0; gi < aus_pkg::DATA_W; gi++) begin : g_flag
        if (aus_pkg::STICKY_MASK[gi]) begin : g_impl
            assign clr_vec[gi] = write_commit & wr_status
                               & w_hold.data[gi] & w_hold.strb[gi/8];
            aus_sticky_flag u_flag (
                .i_mclk       (i_mclk),
                .i_por_resetn (i_por_resetn),
                .i_set        (set_vec[gi]),
                .i_clear      (clr_vec[gi]),
                .o_flag       (status_flags[gi])
            );
        end else begin : g_rsvd
            assign clr_vec[gi]      = 1'b0;
            assign status_flags[gi] = 1'b0;
        end
    end

    // Registered copies for the reporting logic
    // Lag the flags by one cycle to keep outputs flop-driven
    always_ff @(posedge i_mclk) begin
        if (!i_por_resetn) begin
            o_uncorrectable_error_status <= aus_pkg::STATUS_RST;
            o_uncorrectable_pending      <= 1'b0;
        end else begin
            o_uncorrectable_error_status <= status_flags;
            o_uncorrectable_pending      <= |status_flags;
        end
    end

    // ****************
    // Write address decode
    // ****************

    // Word decode; low address bits ignored
    always_comb begin
        wr_header = (aw_hold.addr[aus_pkg::ADDR_W-1:2] ==
                     aus_pkg::OFS_HEADER[aus_pkg::ADDR_W-1:2]);
        wr_status = (aw_hold.addr[aus_pkg::ADDR_W-1:2] ==
                     aus_pkg::OFS_STATUS[aus_pkg::ADDR_W-1:2]);
        wr_mapped = wr_header | wr_status;
    end

    // Commit once both halves are held
    assign write_commit = aw_full & w_full & (wr_state == aus_pkg::WR_COLLECT);

    // ****************
    // Write channels
    // ****************

    // Address and data accepted in either order
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            aw_full   <= 1'b0;
            o_awready <= 1'b0;
            aw_hold   <= '0;
        end else if (o_bvalid && i_bready) begin
            aw_full   <= 1'b0;
            o_awready <= 1'b1;
        end else if (!aw_full && o_awready && i_awvalid) begin
            aw_full   <= 1'b1;
            o_awready <= 1'b0;
            aw_hold   <= i_aw;
        end else if (!aw_full) begin
            o_awready <= 1'b1;
        end
    end

    // Data half of the write
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            w_full   <= 1'b0;
            o_wready <= 1'b0;
            w_hold   <= '0;
        end else if (o_bvalid && i_bready) begin
            w_full   <= 1'b0;
            o_wready <= 1'b1;
        end else if (!w_full && o_wready && i_wvalid) begin
            w_full   <= 1'b1;
            o_wready <= 1'b0;
            w_hold   <= i_w;
        end else if (!w_full) begin
            o_wready <= 1'b1;
        end
    end

    // Write response; one write in flight at a time
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            wr_state <= aus_pkg::WR_COLLECT;
            o_bvalid <= 1'b0;
            o_bresp  <= aus_pkg::RESP_OKAY;
        end else begin
            unique case (wr_state)
                aus_pkg::WR_COLLECT: begin
                    if (write_commit) begin
                        wr_state <= aus_pkg::WR_RESPOND;
                        o_bvalid <= 1'b1;
                        o_bresp  <= wr_mapped ? aus_pkg::RESP_OKAY
                                              : aus_pkg::RESP_SLVERR;
                    end
                end
                aus_pkg::WR_RESPOND: begin
                    if (i_bready) begin
                        wr_state <= aus_pkg::WR_COLLECT;
                        o_bvalid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************
    // Read channel
    // ****************

    // Read address decode straight off the bus
    always_comb begin
        ar_take   = o_arready & i_arvalid;
        rd_header = (i_ar.addr[aus_pkg::ADDR_W-1:2] ==
                     aus_pkg::OFS_HEADER[aus_pkg::ADDR_W-1:2]);
        rd_status = (i_ar.addr[aus_pkg::ADDR_W-1:2] ==
                     aus_pkg::OFS_STATUS[aus_pkg::ADDR_W-1:2]);
        next_r    = '0;
        if (rd_header) begin
            next_r.data = header_word;
            next_r.resp = aus_pkg::RESP_OKAY;
        end else if (rd_status) begin
            next_r.data = status_flags;
            next_r.resp = aus_pkg::RESP_OKAY;
        end else begin
            next_r.resp = aus_pkg::RESP_SLVERR;
        end
    end

    // Read data captured at the address handshake
    // Reads have no side effects, so a stalled rready is harmless
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rd_state  <= aus_pkg::RD_IDLE;
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_r       <= '0;
        end else begin
            unique case (rd_state)
                aus_pkg::RD_IDLE: begin
                    if (ar_take) begin
                        rd_state  <= aus_pkg::RD_RESPOND;
                        o_arready <= 1'b0;
                        o_rvalid  <= 1'b1;
                        o_r       <= next_r;
                    end else begin
                        o_arready <= 1'b1;
                    end
                end
                aus_pkg::RD_RESPOND: begin
                    if (i_rready) begin
                        rd_state  <= aus_pkg::RD_IDLE;
                        o_arready <= 1'b1;
                        o_rvalid  <= 1'b0;
                    end
                end
            endcase
        end
    end

endmodule

// *** aus_assertions.sv ***
// Purpose: Port checker for the status bank
// Assumes: Sees top module ports only; bound at the foot
// Notes:   A detection pulse shows on the status output two edges later
`timescale 1ns/1ps
module aus_assertions (
    input  wire logic           i_mclk,
    input  wire logic           i_resetn,
    input  wire logic           i_por_resetn,
    input  aus_pkg::aus_event_t i_event,
    input  wire logic           i_surprise_down_report_capable,
    input  wire logic           i_arvalid,
    input  aus_pkg::aus_addr_t  i_ar,
    input  wire logic           o_arready,
    input  wire logic           o_rvalid,
    input  aus_pkg::aus_rdata_t o_r,
    input  wire logic [31:0]    o_uncorrectable_error_status
);
    // ****************
    // Helper logic and properties
    // ****************
    logic [31:0] ev_mask;
    // Event-to-bit map; surprise down has its own gate
    assign ev_mask = {8'h0, i_event.multicast_blocked, i_event.internal_error,
                      i_event.access_control_violation, i_event.unsupported_request,
                      i_event.ecrc_error, i_event.malformed_tlp, i_event.receiver_overflow,
                      i_event.unexpected_completion, 2'h0, i_event.flow_control_error,
                      i_event.poisoned_tlp, 7'h0, i_event.link_protocol_error, 4'h0};

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_por_resetn);

    sequence s_event_seen;
        ev_mask != 32'h0;
    endsequence
    sequence s_read_taken;
        i_arvalid && o_arready;
    endsequence
    property p_event_sets;
        s_event_seen |-> ##2 ((o_uncorrectable_error_status & $past(ev_mask, 2)) == $past(ev_mask, 2));
    endproperty
    property p_surprise_set;
        i_event.surprise_down && i_surprise_down_report_capable |-> ##2 o_uncorrectable_error_status[5];
    endproperty
    property p_surprise_gate;
        $rose(o_uncorrectable_error_status[5])
            |-> $past(i_event.surprise_down && i_surprise_down_report_capable, 2);
    endproperty
    property p_reserved_zero;
        (o_uncorrectable_error_status & ~aus_pkg::STICKY_MASK) == 32'h0;
    endproperty
    property p_bit0_clear;
        o_uncorrectable_error_status[0] == 1'b0;
    endproperty
    property p_sticky_warm;
        !$past(i_resetn) && !i_resetn
            |=> (o_uncorrectable_error_status & $past(o_uncorrectable_error_status))
                == $past(o_uncorrectable_error_status);
    endproperty
    property p_header_read;
        disable iff (!i_resetn)
        s_read_taken ##0 (i_ar.addr[11:2] == aus_pkg::OFS_HEADER[11:2])
            |=> o_rvalid && o_r.data[19:0] == {aus_pkg::CAP_VER, aus_pkg::CAP_ID};
    endproperty
    property p_unmapped_read;
        disable iff (!i_resetn)
        s_read_taken ##0 (i_ar.addr[11:2] != aus_pkg::OFS_HEADER[11:2])
            ##0 (i_ar.addr[11:2] != aus_pkg::OFS_STATUS[11:2])
            |=> o_rvalid && o_r.resp == aus_pkg::RESP_SLVERR && o_r.data == 32'h0;
    endproperty

    a_event_sets: assert property (p_event_sets) else $error("event bit not set");
    a_surprise_set: assert property (p_surprise_set) else $error("surprise bit not set");
    a_surprise_gate: assert property (p_surprise_gate) else $error("surprise bit set ungated");
    a_reserved_zero: assert property (p_reserved_zero) else $error("fixed bit nonzero");
    a_bit0_clear: assert property (p_bit0_clear) else $error("unused bit set");
    a_sticky_warm: assert property (p_sticky_warm) else $error("flag lost in warm reset");
    a_header_read: assert property (p_header_read) else $error("header constants wrong");
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read wrong");
endmodule

bind aer_uncorrectable_status aus_assertions u_chk (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_por_resetn(i_por_resetn), .i_event(i_event),
    .i_surprise_down_report_capable(i_surprise_down_report_capable), .i_arvalid(i_arvalid),
    .i_ar(i_ar), .o_arready(o_arready), .o_rvalid(o_rvalid), .o_r(o_r),
    .o_uncorrectable_error_status(o_uncorrectable_error_status)
);

// *** aus_link_model.sv ***
// Purpose: Link layer stand-in raising detection pulses
// Assumes: Bench hands over a one-cycle request mask
// Notes:   Pulses last one cycle and rest low between them
`timescale 1ns/1ps
module aus_link_model (
    input  wire logic           i_mclk,
    input  wire logic [11:0]    i_request,
    input  wire logic           i_capable,
    output aus_pkg::aus_event_t o_event,
    output logic                o_capable
);
    // ****************
    // Detection pulses
    // ****************
    // gate travels with pulse
    // Registered so gate and pulse land on one edge
    always_ff @(posedge i_mclk) begin
        o_event   <= aus_pkg::aus_event_t'(i_request);
        o_capable <= i_capable;
    end
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the status bank
// Assumes: Link stand-in makes detection pulses
// Notes:   Expected values from a model of the bank
`timescale 1ns/1ps
module tb;
    logic                clk = 1'b0;
    logic                rstn = 1'b0;
    logic                por_n = 1'b0;
    logic [11:0]         req = 12'h0;
    logic                cap = 1'b0;
    logic                unlock = 1'b0;
    logic                awvalid = 1'b0;
    logic                wvalid = 1'b0;
    logic                bready = 1'b0;
    logic                arvalid = 1'b0;
    logic                rready = 1'b0;
    aus_pkg::aus_addr_t  aw = '0;
    aus_pkg::aus_addr_t  ar = '0;
    aus_pkg::aus_wdata_t w = '0;
    aus_pkg::aus_event_t ev;
    aus_pkg::aus_rdata_t r;
    logic                cap_q, awready, wready, bvalid, arready, rvalid, pend;
    logic [1:0]          bresp;
    logic [31:0]         status_o;
    logic [31:0]         exp_st = 32'h0;
    logic [11:0]         exp_ptr = aus_pkg::NEXT_PTR_RST;
    int                  failures = 0;
    int                  comparisons = 0;
    int                  seed = 10030;
    int                  bitpos [12] = '{4, 5, 12, 13, 16, 17, 18, 19, 20, 21, 22, 23};

    initial forever #10 clk = ~clk;

    aer_uncorrectable_status dut (.i_mclk(clk), .i_resetn(rstn), .i_por_resetn(por_n),
        .i_event(ev), .i_surprise_down_report_capable(cap_q), .i_next_pointer_unlock(unlock),
        .i_awvalid(awvalid), .i_aw(aw), .o_awready(awready), .i_wvalid(wvalid), .i_w(w),
        .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
        .i_arvalid(arvalid), .i_ar(ar), .o_arready(arready), .o_rvalid(rvalid), .o_r(r),
        .i_rready(rready), .o_uncorrectable_error_status(status_o),
        .o_uncorrectable_pending(pend));
    aus_link_model u_link (.i_mclk(clk), .i_request(req), .i_capable(cap), .o_event(ev),
        .o_capable(cap_q));

    // ****************
    // Tasks
    // ****************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Handshakes sampled at the falling edge, away from the design
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] rs);
        logic aw_hs, w_hs, b_hs;
        b_hs = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        aw <= '{addr: a, prot: 3'h0};
        wvalid <= 1'b1;
        w <= '{data: d, strb: s};
        bready <= 1'b1;
        while (!b_hs) begin
            @(negedge clk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            rs = bresp;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ar_hs, r_hs;
        r_hs = 1'b0;
        @(posedge clk);
        arvalid <= 1'b1;
        ar <= '{addr: a, prot: 3'h0};
        rready <= 1'b1;
        while (!r_hs) begin
            @(negedge clk);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            d = r.data;
            rs = r.resp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    // Pulse through the link stand-in and update the expected flags
    task automatic fire(input logic [11:0] m, input logic c);
        @(posedge clk);
        req <= m;
        cap <= c;
        @(posedge clk);
        req <= 12'h0;
        for (int k = 0; k < 12; k++) begin
            if (m[11-k] && (k != 1 || c)) exp_st[bitpos[k]] = 1'b1;
        end
        repeat (3) @(posedge clk);
    endtask

    task automatic st_chk;
        logic [31:0] d;
        logic [1:0]  rs;
        axr(aus_pkg::OFS_STATUS, d, rs);
        chk("status read", d, exp_st);
        chk("status resp", {30'h0, rs}, {30'h0, aus_pkg::RESP_OKAY});
        chk("status port", status_o, exp_st);
        chk("pending", {31'h0, pend}, {31'h0, exp_st != 32'h0});
    endtask

    task automatic hdr_chk;
        logic [31:0] d;
        logic [1:0]  rs;
        axr(aus_pkg::OFS_HEADER, d, rs);
        chk("header", d, {exp_ptr, aus_pkg::CAP_VER, aus_pkg::CAP_ID});
    endtask

    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************
    // Sequence of tests
    // ****************
    initial begin
        #400000;
        failures++;
        close_out();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  rs;
        logic [3:0]  s;
        logic        c;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        @(posedge clk);
        hdr_chk();
        st_chk();
        $display("reset values done");
        // Every detection alone; the 13th pass is surprise down with the gate on
        for (int k = 0; k < 13; k++) begin
            fire((k < 12) ? (12'h800 >> k) : 12'h400, k == 12);
            st_chk();
        end
        $display("detections done");
        // Random lane clears interleaved with random bursts of detections
        for (int n = 0; n < 8; n++) begin
            s = 4'($random(seed));
            d = $random(seed);
            axw(aus_pkg::OFS_STATUS, d, s, rs);
            for (int l = 0; l < 4; l++) begin
                if (s[l]) exp_st = exp_st & ~(d & (32'hff << (8 * l)));
            end
            st_chk();
            c = 1'($random(seed));
            fire(12'($random(seed)), c);
            st_chk();
        end
        axw(aus_pkg::OFS_STATUS, 32'hffff_ffff, 4'hf, rs);
        exp_st = 32'h0;
        st_chk();
        $display("clears done");
        // Pointer writes under a random lock, random lanes
        for (int n = 0; n < 8; n++) begin
            c = 1'($random(seed));
            unlock <= c;
            s = 4'($random(seed));
            d = $random(seed);
            axw(aus_pkg::OFS_HEADER, d, s, rs);
            chk("ptr resp", {30'h0, rs}, {30'h0, aus_pkg::RESP_OKAY});
            if (c && s[3]) exp_ptr[11:4] = d[31:24];
            if (c && s[2]) exp_ptr[3:0] = d[23:20];
            hdr_chk();
        end
        $display("pointer done");
        axw(12'h108, 32'hffff_ffff, 4'hf, rs);
        chk("unmapped wr resp", {30'h0, rs}, {30'h0, aus_pkg::RESP_SLVERR});
        axr(12'h108, d, rs);
        chk("unmapped rd data", d, 32'h0);
        chk("unmapped rd resp", {30'h0, rs}, {30'h0, aus_pkg::RESP_SLVERR});
        st_chk();
        $display("unmapped done");
        // Warm reset keeps flags and reloads the pointer; power-on clears flags
        fire(12'hfff, 1'b1);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        st_chk();
        exp_ptr = aus_pkg::NEXT_PTR_RST;
        hdr_chk();
        rstn <= 1'b0;
        por_n <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        @(posedge clk);
        exp_st = 32'h0;
        st_chk();
        $display("resets done");
        close_out();
    end
endmodule
